// ### design/ddr3_cmd_pkg.sv
// Purpose: shared constants for the ddr3 command core
// Assumes: one 25 MHz clock, synchronous active-low reset
// Notes:   byte offsets, control bits, timing counts
package ddr3_cmd_pkg;
    localparam int BA_W     = 3;
    localparam int BANKS    = 8;
    localparam int AVS_AW   = 4;
    // register byte offsets
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_BANKS  = 4'h8;
    localparam logic [3:0] REG_REJECT = 4'hC;
    // control register fields
    localparam int CTL_MPR_EN    = 0;
    localparam int CTL_MPR_SEL   = 1;
    localparam int CTL_ALL_DQ    = 3;
    localparam int CTL_OTF       = 4;
    localparam int CTL_FIX_BC4   = 5;
    localparam int CTL_DLL_LOCK  = 6;
    localparam int CTL_INIT_DONE = 7;
    localparam logic [7:0] CTRL_RESET  = 8'h10;
    localparam logic [7:0] MPR_PATTERN = 8'hAA;
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int TRP_NS        = 15;
    localparam int TRFC_NS       = 160;
    localparam int TRP_RAW  = (TRP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TRFC_RAW = (TRFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] TRP_CYC  = 4'((TRP_RAW < 1) ? 1 : TRP_RAW);
    localparam logic [7:0] TRFC_CYC = 8'((TRFC_RAW < 1) ? 1 : TRFC_RAW);
    localparam logic [9:0] ZQCS_CYC   = 10'h040;
    localparam logic [9:0] ZQOPER_CYC = 10'h100;
    localparam logic [9:0] ZQINIT_CYC = 10'h200;
    typedef enum logic [3:0] {
        CMD_MRS = 4'h0, CMD_REF = 4'h1, CMD_PRE = 4'h2, CMD_ACT = 4'h3,
        CMD_WR  = 4'h4, CMD_RD  = 4'h5, CMD_ZQ  = 4'h6, CMD_NOP = 4'h7
    } cmd_t;
    typedef enum logic [1:0] {
        B_IDLE = 2'h0, B_LAT = 2'h1, B_DATA = 2'h3
    } burst_st_t;
endpackage

// ### design/array_port_if.sv
// Purpose: array access port between core and storage
// Assumes: one write or one read per clock
// Notes:   read data registered inside the storage
`timescale 1ns/10ps
`default_nettype none
interface array_port_if #(parameter int DW = 16, parameter int AW = 8);
    logic            we;
    logic [DW/8-1:0] be;
    logic [AW-1:0]   addr;
    logic [DW-1:0]   wdata;
    logic [DW-1:0]   rdata;
    modport ctl (output we, be, addr, wdata, input rdata);
    modport mem (input we, be, addr, wdata, output rdata);
endinterface
`default_nettype wire

// ### design/ddr_array_mem.sv
// Purpose: byte-writable storage array
// Assumes: addr stable across the clock edge
// Notes:   contents persist through self refresh
`timescale 1ns/10ps
`default_nettype none
module ddr_array_mem #(
    parameter int DW = 16,
    parameter int AW = 8
) (
    input  wire logic   sys_clk_i,
    array_port_if.mem   port
);
    for (genvar g = 0; g < DW / 8; g++) begin : g_lane
        logic [7:0] arr [2**AW];
        always_ff @(posedge sys_clk_i) begin
            if (port.we && port.be[g]) begin
                arr[port.addr] <= port.wdata[g*8+:8];
            end
        end
        always_ff @(posedge sys_clk_i) begin
            port.rdata[g*8+:8] <= arr[port.addr];
        end
    end
endmodule
`default_nettype wire

// ### design/zq_cal_engine.sv
// Purpose: impedance calibration sequencer
// Assumes: start pulses only while idle
// Notes:   drive code jumps to its target when a long run ends, steps one toward it when a short run ends
`timescale 1ns/10ps
`default_nettype none
module zq_cal_engine #(
    parameter logic [3:0] TARGET = 4'h8
) (
    input  wire logic       sys_clk_i,
    input  wire logic       nrst_i,
    input  wire logic       start_long_i,
    input  wire logic       start_short_i,
    input  wire logic       init_done_i,
    output logic            busy_o,
    output logic [3:0]      code_o
);
    import ddr3_cmd_pkg::*;
    logic [9:0] cnt_q;
    logic       long_q;
    logic [3:0] code_q;

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            cnt_q  <= '0;
            long_q <= 1'b0;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 10'h001;
        end else if (start_long_i) begin
            cnt_q  <= init_done_i ? ZQOPER_CYC : ZQINIT_CYC;
            long_q <= 1'b1;
        end else if (start_short_i) begin
            cnt_q  <= ZQCS_CYC;
            long_q <= 1'b0;
        end
    end

    // values applied to drivers at end of run
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            code_q <= 4'h0;
        end else if (cnt_q == 10'h001) begin
            if (long_q || code_q == TARGET) begin
                code_q <= TARGET;
            end else if (code_q < TARGET) begin
                code_q <= code_q + 4'h1;
            end else begin
                code_q <= code_q - 4'h1;
            end
        end
    end

    assign busy_o = (cnt_q != '0);
    assign code_o = code_q;
endmodule
`default_nettype wire

// ### design/ddr3_cmd_core.sv
// Purpose: ddr3 device command, burst and readout core
// Assumes: command pins driven on sys_clk_i by logic
// Notes:   registers on avalon-mm with one wait state
`timescale 1ns/10ps
`default_nettype none
module ddr3_cmd_core #(
    parameter int DW      = 16,
    parameter int ROW_LOW = 2,
    parameter int RL_CYC  = 5,
    parameter int WL_CYC  = 4
) (
    input  wire logic                           sys_clk_i,
    input  wire logic                           nrst_i,
    input  wire logic [ddr3_cmd_pkg::AVS_AW-1:0] avs_address_i,
    input  wire logic                           avs_read_i,
    input  wire logic                           avs_write_i,
    input  wire logic [31:0]                    avs_writedata_i,
    input  wire logic [3:0]                     avs_byteenable_i,
    output logic [31:0]                         avs_readdata_o,
    output logic                                avs_waitrequest_o,
    input  wire logic                           cke_i,
    input  wire logic                           cs_n_i,
    input  wire logic                           ras_n_i,
    input  wire logic                           cas_n_i,
    input  wire logic                           we_n_i,
    input  wire logic [ddr3_cmd_pkg::BA_W-1:0]  ba_i,
    input  wire logic [13:0]                    addr_i,
    input  wire logic [DW-1:0]                  dq_i,
    input  wire logic [DW/8-1:0]                dm_i,
    output logic [DW-1:0]                       dq_o,
    output logic                                dq_oe_o
);
    import ddr3_cmd_pkg::*;
    localparam int AW = BA_W + ROW_LOW + 3;
    localparam logic [3:0] RL_LAT = 4'(RL_CYC - 3);
    localparam logic [3:0] WL_LAT = 4'(WL_CYC - 2);

    logic [7:0]         ctrl_q;
    logic [BANKS-1:0]   open_w;
    logic [BANKS-1:0]   prech_w;
    logic [ROW_LOW-1:0] row_w [BANKS];
    burst_st_t          bst_q;
    logic [3:0]         lat_q;
    logic [2:0]         beat_q;
    logic               is_wr_q;
    logic               bc4_q;
    logic               ap_q;
    logic               mpr_q;
    logic [2:0]         col_q;
    logic [BA_W-1:0]    bank_q;
    logic [2:0]         bcol;
    logic [7:0]         ref_cnt_q;
    logic [7:0]         ref_row_q;
    logic               sr_q;
    logic               p1_v_q;
    logic               p1_mpr_q;
    logic [2:0]         p1_beat_q;
    logic [DW-1:0]      dq_q;
    logic               dq_oe_q;
    logic               wait_q;
    logic [31:0]        rdata_q;
    logic [15:0]        reject_q;
    logic               zq_busy;
    logic [3:0]         zq_code;
    cmd_t               cmd;
    logic               cmd_v;
    logic               mpr_en;
    logic               ref_busy;
    logic               busy_core;
    logic               act_go;
    logic               rd_go;
    logic               wr_go;
    logic               pre_go;
    logic               ref_go;
    logic               sre_go;
    logic               zq_go;
    logic               refused;
    logic               burst_end;
    logic               req;
    logic [31:0]        status_w;
    logic [31:0]        banks_w;

    array_port_if #(.DW(DW), .AW(AW)) mif ();

    ddr_array_mem #(.DW(DW), .AW(AW)) u_mem (
        .sys_clk_i (sys_clk_i),
        .port      (mif.mem)
    );

    zq_cal_engine u_zq (
        .sys_clk_i     (sys_clk_i),
        .nrst_i        (nrst_i),
        .start_long_i  (zq_go && addr_i[10]),
        .start_short_i (zq_go && !addr_i[10]),
        .init_done_i   (ctrl_q[CTL_INIT_DONE]),
        .busy_o        (zq_busy),
        .code_o        (zq_code)
    );

    // command decode
    assign cmd       = cmd_t'({1'b0, ras_n_i, cas_n_i, we_n_i});
    assign cmd_v     = !cs_n_i && cke_i && !sr_q;
    assign mpr_en    = ctrl_q[CTL_MPR_EN];
    assign ref_busy  = (ref_cnt_q != 8'h00);
    assign busy_core = ref_busy || zq_busy;
    assign act_go    = cmd_v && cmd == CMD_ACT && !busy_core && !mpr_en
                       && !open_w[ba_i] && !prech_w[ba_i];
    assign rd_go     = cmd_v && cmd == CMD_RD && bst_q == B_IDLE && !busy_core
                       && (mpr_en ? ctrl_q[CTL_DLL_LOCK] : open_w[ba_i]);
    assign wr_go     = cmd_v && cmd == CMD_WR && bst_q == B_IDLE && !busy_core
                       && !mpr_en && open_w[ba_i];
    assign pre_go    = cmd_v && cmd == CMD_PRE && !mpr_en;
    assign ref_go    = cmd_v && cmd == CMD_REF && !busy_core && !mpr_en;
    assign sre_go    = !cs_n_i && !cke_i && !sr_q && cmd == CMD_REF
                       && !busy_core && !mpr_en;
    assign zq_go     = cmd_v && cmd == CMD_ZQ && !busy_core && bst_q == B_IDLE;
    assign refused   = cmd_v && cmd != CMD_NOP && cmd != CMD_MRS && !act_go
                       && !rd_go && !wr_go && !pre_go && !ref_go && !zq_go;
    assign burst_end = bst_q == B_DATA && beat_q == (bc4_q ? 3'h3 : 3'h7);

    // burst sequencer
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            bst_q  <= B_IDLE;
            lat_q  <= 4'h0;
            beat_q <= 3'h0;
        end else begin
            unique case (bst_q)
                B_IDLE: begin
                    if (rd_go || wr_go) begin
                        bst_q  <= B_LAT;
                        lat_q  <= rd_go ? RL_LAT : WL_LAT;
                        beat_q <= 3'h0;
                    end
                end
                B_LAT: begin
                    if (lat_q == 4'h0) begin
                        bst_q <= B_DATA;
                    end else begin
                        lat_q <= lat_q - 4'h1;
                    end
                end
                B_DATA: begin
                    if (burst_end) begin
                        bst_q <= B_IDLE;
                    end else begin
                        beat_q <= beat_q + 3'h1;
                    end
                end
                default: bst_q <= B_IDLE;
            endcase
        end
    end

    // burst attributes caught with the command
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            is_wr_q <= 1'b0;
            bc4_q   <= 1'b0;
            ap_q    <= 1'b0;
            mpr_q   <= 1'b0;
            col_q   <= 3'h0;
            bank_q  <= '0;
        end else if (rd_go || wr_go) begin
            is_wr_q <= wr_go;
            bc4_q   <= ctrl_q[CTL_OTF] ? !addr_i[12] : ctrl_q[CTL_FIX_BC4];
            ap_q    <= addr_i[10] && !mpr_en;
            mpr_q   <= mpr_en;
            col_q   <= mpr_en ? {addr_i[2], 2'b00} : addr_i[2:0];
            bank_q  <= ba_i;
        end
    end

    // beat column, wraps inside the nibble for chop
    assign bcol = bc4_q ? {col_q[2], 2'(col_q[1:0] + beat_q[1:0])}
                        : 3'(col_q + beat_q);

    always_comb begin
        mif.we    = bst_q == B_DATA && is_wr_q;
        mif.be    = ~dm_i;
        mif.addr  = {bank_q, row_w[bank_q], bcol};
        mif.wdata = dq_i;
    end

    // per-bank row state
    for (genvar b = 0; b < BANKS; b++) begin : g_bank
        logic               open_q;
        logic [3:0]         rp_q;
        logic [ROW_LOW-1:0] row_q;
        logic               hit_pre;
        assign hit_pre = (pre_go && (addr_i[10] || ba_i == BA_W'(b)))
                         || (burst_end && ap_q && bank_q == BA_W'(b));
        always_ff @(posedge sys_clk_i) begin
            if (!nrst_i) begin
                open_q <= 1'b0;
                rp_q   <= 4'h0;
                row_q  <= '0;
            end else if (hit_pre) begin
                if (open_q || rp_q != 4'h0) begin
                    rp_q <= TRP_CYC;
                end
                open_q <= 1'b0;
            end else if (act_go && ba_i == BA_W'(b)) begin
                open_q <= 1'b1;
                row_q  <= addr_i[ROW_LOW-1:0];
            end else if (rp_q != 4'h0) begin
                rp_q <= rp_q - 4'h1;
            end
        end
        assign open_w[b]  = open_q;
        assign prech_w[b] = rp_q != 4'h0;
        assign row_w[b]   = row_q;
    end

    // refresh and self refresh
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            ref_cnt_q <= 8'h00;
            ref_row_q <= 8'h00;
        end else if (ref_go) begin
            ref_cnt_q <= TRFC_CYC;
            ref_row_q <= ref_row_q + 8'h01;
        end else if (ref_busy) begin
            ref_cnt_q <= ref_cnt_q - 8'h01;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            sr_q <= 1'b0;
        end else if (sre_go) begin
            sr_q <= 1'b1;
        end else if (sr_q && cke_i) begin
            sr_q <= 1'b0;
        end
    end

    // readout word for the calibration pattern
    function automatic logic [DW-1:0] mpr_word(input logic [2:0] b);
        logic          bit_v;
        logic [DW-1:0] w;
        bit_v = ctrl_q[CTL_MPR_SEL+:2] == 2'b00 && MPR_PATTERN[b];
        w     = '0;
        for (int i = 0; i < DW; i++) begin
            if (ctrl_q[CTL_ALL_DQ] || i % 8 == 0) begin
                w[i] = bit_v;
            end
        end
        return w;
    endfunction

    // read pipeline: array read, then output stage
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            p1_v_q    <= 1'b0;
            p1_mpr_q  <= 1'b0;
            p1_beat_q <= 3'h0;
            dq_oe_q   <= 1'b0;
            dq_q      <= '0;
        end else begin
            p1_v_q    <= bst_q == B_DATA && !is_wr_q;
            p1_mpr_q  <= mpr_q;
            p1_beat_q <= bcol;
            dq_oe_q   <= p1_v_q;
            if (!p1_v_q) begin
                dq_q <= '0;
            end else if (p1_mpr_q) begin
                dq_q <= mpr_word(p1_beat_q);
            end else begin
                dq_q <= mif.rdata;
            end
        end
    end

    // avalon-mm slave, one wait state
    assign req      = avs_read_i || avs_write_i;
    assign status_w = {20'h0, zq_code, 3'h0, sr_q, zq_busy, ref_busy,
                       bst_q != B_IDLE && is_wr_q, bst_q != B_IDLE && !is_wr_q};
    assign banks_w  = {ref_row_q, 8'h00, prech_w, open_w};

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= !(req && wait_q);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            rdata_q <= 32'h0;
        end else if (avs_read_i && wait_q) begin
            case (avs_address_i)
                REG_CTRL:   rdata_q <= {24'h0, ctrl_q};
                REG_STATUS: rdata_q <= status_w;
                REG_BANKS:  rdata_q <= banks_w;
                REG_REJECT: rdata_q <= {16'h0, reject_q};
                default:    rdata_q <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            ctrl_q <= CTRL_RESET;
        end else if (avs_write_i && !wait_q && avs_address_i == REG_CTRL
                     && avs_byteenable_i[0]) begin
            ctrl_q <= avs_writedata_i[7:0];
        end
    end

    // refused command count, write clears, a refusal in the clearing cycle leaves one
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            reject_q <= 16'h0;
        end else if (refused) begin
            reject_q <= (avs_write_i && !wait_q && avs_address_i == REG_REJECT)
                        ? 16'h1 : reject_q + 16'h1;
        end else if (avs_write_i && !wait_q && avs_address_i == REG_REJECT) begin
            reject_q <= 16'h0;
        end
    end

    assign avs_readdata_o    = rdata_q;
    assign avs_waitrequest_o = wait_q;
    assign dq_o              = dq_q;
    assign dq_oe_o           = dq_oe_q;

    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_bl8;
        dq_oe_q [*8] ##1 !dq_oe_q;
    endsequence
    sequence s_bc4;
        dq_oe_q [*4] ##1 !dq_oe_q;
    endsequence

    a_read_bl8_run: assert property (rd_go ##1 !bc4_q |-> ##RL_CYC s_bl8)
        else $error("read burst of eight broken");
    a_read_bc4_run: assert property (rd_go ##1 bc4_q |-> ##RL_CYC s_bc4)
        else $error("chopped read burst wrong length");
    a_mpr_beat_bit: assert property (dq_oe_q && $past(p1_mpr_q)
        && ctrl_q[2:1] == 2'b00 |-> dq_q[0] == MPR_PATTERN[$past(p1_beat_q)])
        else $error("pattern bit out of order");
    a_prime_dq_low: assert property (dq_oe_q && $past(p1_mpr_q)
        && !ctrl_q[CTL_ALL_DQ] |-> dq_q[7:1] == 7'h00)
        else $error("non-prime dq not low");
    a_act_opens_bank: assert property (act_go |=> open_w[$past(ba_i)])
        else $error("activate did not open bank");
    a_pre_all_close: assert property (pre_go && addr_i[10] |=> open_w == '0)
        else $error("precharge all left a bank open");
    a_autopre_close: assert property (burst_end && ap_q
        |=> !open_w[$past(bank_q)] && prech_w[$past(bank_q)])
        else $error("auto precharge missed");
    a_refresh_busy: assert property (ref_go |=> ref_busy [*4] ##1 !ref_busy)
        else $error("refresh busy window wrong");
    a_deselect_idle: assert property (cs_n_i && bst_q == B_IDLE
        |=> bst_q == B_IDLE)
        else $error("burst started on deselect");
    a_selfref_hold: assert property (sr_q && !cke_i |=> sr_q)
        else $error("self refresh left without cke");
endmodule
`default_nettype wire

// ### verification/ctl_model.sv
// Purpose: controller side driving ddr3 command, address and write data
// Assumes: every change lands just after a rising edge
// Notes:   released data lines show the inverse of their last value
`timescale 1ns/10ps
`default_nettype none
module ctl_model #(parameter int WL = 4) (
    input  wire logic        clk_i,
    output logic             cke_o,
    output logic             cs_n_o,
    output logic [2:0]       rcw_o,
    output logic [2:0]       ba_o,
    output logic [13:0]      a_o,
    output logic [15:0]      dq_o,
    output logic [1:0]       dm_o
);
    initial begin
        cke_o = 1'b1;
        cs_n_o = 1'b1;
        rcw_o = 3'h7;
        ba_o = 3'h0;
        a_o = 14'h0;
        dq_o = 16'h0;
        dm_o = 2'h0;
    end
    task automatic set_cke(input logic v);
        @(posedge clk_i);
        cke_o <= v;
    endtask
    // one command cycle, then deselect
    task automatic cmd(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a);
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        rcw_o <= c;
        ba_o <= b;
        a_o <= a;
        @(posedge clk_i);
        cs_n_o <= 1'b1;
        rcw_o <= 3'h7;
    endtask
    // eight-beat write, bank opened beforehand
    task automatic wr(input logic [2:0] b, input logic [13:0] a,
                      input logic [15:0] d [8], input logic [1:0] m [8]);
        cmd(3'h4, b, a);
        repeat (WL - 1) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            dq_o <= d[i];
            dm_o <= m[i];
            @(posedge clk_i);
        end
        dq_o <= ~d[7];
        dm_o <= ~m[7];
    endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
// Purpose: self-checking bench for the ddr3 command core
// Assumes: 25 MHz clock, synchronous active-low reset
// Notes:   mpr cases table driven, the rest hand written
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import ddr3_cmd_pkg::*;
    localparam int RL = 5;
    localparam int WL = 4;
    typedef struct packed {
        logic [7:0] ctrl; logic a12; logic a2; logic [3:0] n; logic [2:0] first; logic all;
    } row_t;
    row_t rows [6] = '{'{8'h51, 1'b1, 1'b0, 4'h8, 3'h0, 1'b0}, '{8'h51, 1'b0, 1'b0, 4'h4, 3'h0, 1'b0},
        '{8'h51, 1'b0, 1'b1, 4'h4, 3'h4, 1'b0}, '{8'h59, 1'b1, 1'b0, 4'h8, 3'h0, 1'b1},
        '{8'h61, 1'b1, 1'b1, 4'h4, 3'h4, 1'b0}, '{8'h11, 1'b1, 1'b0, 4'h0, 3'h0, 1'b0}};
    logic clk, nrst, av_rd, av_wr, wt, oe, cke, cs_n;
    logic [3:0] av_a;
    logic [31:0] av_wd, rdq, av_q;
    logic [2:0] rcw, ba;
    logic [13:0] a;
    logic [15:0] dq_d, dq_q;
    logic [15:0] d1 [8], d2 [8], bt [8];
    logic [1:0] dm, m0 [8], m2 [8];
    int errors, comparisons, nb, fb;
    logic pb;
    logic [15:0] ew;
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    ctl_model #(.WL(WL)) ctl_model_inst (.clk_i(clk), .cke_o(cke), .cs_n_o(cs_n), .rcw_o(rcw),
        .ba_o(ba), .a_o(a), .dq_o(dq_d), .dm_o(dm));
    ddr3_cmd_core #(.DW(16), .ROW_LOW(2), .RL_CYC(RL), .WL_CYC(WL)) ddr3_cmd_core_inst (
        .sys_clk_i(clk), .nrst_i(nrst), .avs_address_i(av_a), .avs_read_i(av_rd),
        .avs_write_i(av_wr), .avs_writedata_i(av_wd), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdq), .avs_waitrequest_o(wt), .cke_i(cke), .cs_n_i(cs_n),
        .ras_n_i(rcw[2]), .cas_n_i(rcw[1]), .we_n_i(rcw[0]), .ba_i(ba), .addr_i(a),
        .dq_i(dq_d), .dm_i(dm), .dq_o(dq_q), .dq_oe_o(oe));
    task automatic test_done();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic av(input logic w, input logic [3:0] ad, input logic [31:0] wd);
        int n;
        @(posedge clk);
        av_wr <= w;
        av_rd <= !w;
        av_a <= ad;
        av_wd <= wd;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wt !== 1'b0 && n < 50);
        if (n >= 50) begin
            errors++;
            test_done();
        end
        av_q = rdq;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
    endtask
    task automatic rdb(input logic [2:0] b, input logic [13:0] ad);
        nb = 0;
        fb = 0;
        ctl_model_inst.cmd(3'h5, b, ad);
        for (int k = 1; k <= 16; k++) begin
            @(negedge clk);
            if (oe === 1'b1 && nb < 8) begin
                if (nb == 0)
                    fb = k;
                bt[nb] = dq_q;
                nb++;
            end
        end
    endtask
    function automatic logic [31:0] ex(input int c);
        logic [15:0] e;
        e = d2[c];
        if (m2[c][0])
            e[7:0] = d1[c][7:0];
        if (m2[c][1])
            e[15:8] = d1[c][15:8];
        return {16'h0, e};
    endfunction
    initial begin
        errors = 0;
        comparisons = 0;
        nrst = 1'b0;
        av_rd = 1'b0;
        av_wr = 1'b0;
        av_a = 4'h0;
        av_wd = 32'h0;
        for (int i = 0; i < 8; i++) begin
            d1[i] = 16'(16'h1357 * (i + 1));
            d2[i] = ~d1[i];
            m0[i] = 2'h0;
            m2[i] = i[0] ? 2'h2 : 2'h1;
        end
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        foreach (rows[r]) begin
            av(1'b1, REG_CTRL, {24'h0, rows[r].ctrl});
            rdb(3'h7, 14'h2FF8 | {1'b0, rows[r].a12, 9'h0, rows[r].a2, 2'h0});
            chk(32'(nb), 32'(rows[r].n));
            if (nb > 0)
                chk(32'(fb), 32'(RL + 1));
            for (int k = 0; k < nb; k++) begin
                pb = MPR_PATTERN[rows[r].first + k];
                ew = rows[r].all ? {16{pb}} : {7'h0, pb, 7'h0, pb};
                chk({16'h0, bt[k]}, {16'h0, ew});
            end
        end
        av(1'b1, REG_CTRL, 32'h53);
        rdb(3'h0, 14'h1000);
        chk(32'(nb), 32'h8);
        for (int k = 0; k < 8; k++)
            chk({16'h0, bt[k]}, 32'h0);
        av(1'b1, REG_CTRL, 32'h50);
        ctl_model_inst.cmd(3'h3, 3'h1, 14'h0);
        ctl_model_inst.cmd(3'h3, 3'h2, 14'h0);
        av(1'b0, REG_BANKS, 32'h0);
        chk(av_q & 32'hFF, 32'h06);
        ctl_model_inst.wr(3'h1, 14'h1000, d1, m0);
        ctl_model_inst.wr(3'h1, 14'h1000, d2, m2);
        rdb(3'h1, 14'h0004);
        chk(32'(nb), 32'h4);
        for (int i = 0; i < 4; i++)
            chk({16'h0, bt[i]}, ex(4 + i));
        rdb(3'h1, 14'h1400);
        chk(32'(nb), 32'h8);
        for (int i = 0; i < 8; i++)
            chk({16'h0, bt[i]}, ex(i));
        av(1'b0, REG_BANKS, 32'h0);
        chk(av_q & 32'hFF, 32'h04);
        rdb(3'h2, 14'h1000);
        chk(32'(nb), 32'h8);
        av(1'b1, REG_REJECT, 32'h0);
        ctl_model_inst.cmd(3'h1, 3'h5, 14'h3FFF);
        rdb(3'h2, 14'h0);
        chk(32'(nb), 32'h0);
        ctl_model_inst.cmd(3'h2, 3'h1, 14'h0);
        ctl_model_inst.cmd(3'h2, 3'h0, 14'h0400);
        av(1'b0, REG_BANKS, 32'h0);
        chk(av_q & 32'hFF, 32'h0);
        av(1'b0, REG_REJECT, 32'h0);
        chk(av_q, 32'h1);
        ctl_model_inst.cmd(3'h6, 3'h0, 14'h0);
        av(1'b0, REG_STATUS, 32'h0);
        chk(av_q & 32'h8, 32'h8);
        repeat (64) @(posedge clk);
        av(1'b0, REG_STATUS, 32'h0);
        chk(av_q & 32'hF08, 32'h100);
        ctl_model_inst.cmd(3'h6, 3'h0, 14'h0400);
        repeat (300) @(posedge clk);
        av(1'b0, REG_STATUS, 32'h0);
        chk(av_q & 32'h8, 32'h8);
        repeat (220) @(posedge clk);
        av(1'b0, REG_STATUS, 32'h0);
        chk(av_q & 32'hF08, 32'h800);
        av(1'b1, REG_CTRL, 32'hD0);
        ctl_model_inst.cmd(3'h6, 3'h0, 14'h0400);
        repeat (240) @(posedge clk);
        av(1'b0, REG_STATUS, 32'h0);
        chk(av_q & 32'h8, 32'h8);
        repeat (16) @(posedge clk);
        av(1'b0, REG_STATUS, 32'h0);
        chk(av_q & 32'h8, 32'h0);
        ctl_model_inst.set_cke(1'b0);
        ctl_model_inst.cmd(3'h1, 3'h0, 14'h0);
        av(1'b0, REG_STATUS, 32'h0);
        chk(av_q & 32'h10, 32'h10);
        ctl_model_inst.set_cke(1'b1);
        repeat (8) @(posedge clk);
        ctl_model_inst.cmd(3'h3, 3'h1, 14'h0);
        rdb(3'h1, 14'h1000);
        chk(32'(nb), 32'h8);
        for (int i = 0; i < 8; i++)
            chk({16'h0, bt[i]}, ex(i));
        @(posedge clk);
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        chk({31'h0, wt}, 32'h1);
        chk({31'h0, oe}, 32'h0);
        chk(rdq, 32'h0);
        chk({16'h0, dq_q}, 32'h0);
        nrst <= 1'b1;
        av(1'b0, REG_CTRL, 32'h0);
        chk(av_q, 32'h10);
        av(1'b0, 4'h6, 32'h0);
        chk(av_q, 32'h0);
        test_done();
    end
endmodule
`default_nettype wire
